// file: design/ssic_map.svh
// constants and address map of the seven-source interrupt controller
//------------------------------------------------------------------------
// Notes on behaviour
// (RL1) port C/D input change on selected pins raises request 0; vector 14H
// (RL2) key-matrix scan input raises request 5; vector 24H when enabled
// (RL3) timer 1 underflow raises request 1, timer 2 request 4; vectors 18H, 20H
// (RL4) pre-divider overflow raises request 3; vector 1CH when enabled
// (RL5) counter-pin mode: second falling edge halts counter, raises request 6, 28H
// (RL6) pre-divider request wins over all others, which stay pending
// (RL7) fixed order: pre-divider, timer 1, timer 2, converter, port, pin, key
// (RL8) acceptance clears all enables; software must re-enable them afterwards
// (RL9) acceptance clears only the accepted source's request flag
// (RL10) acceptance pushes the program counter, then loads the fixed vector
// (RL11) accept in current instruction, next cycle stores PC, then fetch vector
// (RL12) return re-executes the instruction during which acceptance happened
// (RL13) an interrupted halt instruction returns to halt after the routine
// (RL14) set-enables mask bit n drives enable flag n; 7Fh enables all
// (RL15) clear-requests mask clears selected request flags; 7Fh clears all
// (RL16) port-select operand 10h enables change requests from port C
// (RL17) external pin edge, polarity by build option, raises request 2; 10H
// (RL18) external pin held low then high at least one machine cycle each; the code only compares one registered sample with the live pin level
// (RL19) a request raised while disabled stays set until enabled or cleared
//------------------------------------------------------------------------
`ifndef SSIC_MAP_SVH
`define SSIC_MAP_SVH

// register byte offsets
`define SSIC_OFS_ENABLE   8'h00
`define SSIC_OFS_REQUEST  8'h04
`define SSIC_OFS_PORTSEL  8'h08
`define SSIC_OFS_EVSTAT   8'h0c
`define SSIC_OFS_EVMASK   8'h10
`define SSIC_OFS_STATE    8'h14

// source indices
`define SSIC_SRC_PORT     3'h0
`define SSIC_SRC_TIMER1   3'h1
`define SSIC_SRC_PIN      3'h2
`define SSIC_SRC_PREDIV   3'h3
`define SSIC_SRC_TIMER2   3'h4
`define SSIC_SRC_KEY      3'h5
`define SSIC_SRC_CONV     3'h6

// vectors
`define SSIC_VEC_PORT     12'h014
`define SSIC_VEC_TIMER1   12'h018
`define SSIC_VEC_PIN      12'h010
`define SSIC_VEC_PREDIV   12'h01c
`define SSIC_VEC_TIMER2   12'h020
`define SSIC_VEC_KEY      12'h024
`define SSIC_VEC_CONV     12'h028

// port-select fields and reset values
`define SSIC_SEL_PORT_C   4
`define SSIC_SEL_PORT_D   5
`define SSIC_RST_FLAGS    7'h00
`define SSIC_RST_SEL      8'h00
`define SSIC_CONV_SECOND_FALL 2'h2

`endif

// file: design/ssic_pkg.sv
// types shared by the seven-source interrupt controller
package ssic_pkg;

  // interrupt entry sequence
  typedef enum logic [1:0] {
    SSIC_IDLE,
    SSIC_STORE,
    SSIC_FETCH
  } ssic_state_t;

  // single-cycle event pulses from the internal peripherals
  typedef struct packed {
    logic prediv_ovf;
    logic first_timer_uflow;
    logic second_timer_uflow;
    logic key_scan;
  } ssic_src_t;

  // entry commands to the cpu core
  typedef struct packed {
    logic        push;
    logic        nop;
    logic        load;
    logic [11:0] vector;
    logic [11:0] ret_pc;
  } ssic_cpu_t;

endpackage : ssic_pkg

// file: design/ssic_top.sv
// seven-source interrupt controller with apb registers
`timescale 1ns/100ps
`include "ssic_map.svh"

module ssic_top
  import ssic_pkg::*;
#(
  parameter bit EXT_RISING = 1'b1
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  // request sources
  input  wire ssic_src_t   i_src,
  input  wire logic [7:0]  i_port_cd,
  input  wire logic        i_ext_pin,
  input  wire logic        i_conv_mode,
  input  wire logic        i_conv_pin,
  output logic             o_conv_halt,
  // cpu core
  input  wire logic        i_instr_start,
  input  wire logic [11:0] i_pc,
  input  wire logic        i_halt_instr,
  input  wire logic        i_rts,
  output ssic_cpu_t        o_cpu,
  output logic             o_halt_return,
  // interrupt line
  output logic             o_irq
);

  //----------------------------------------------------------------------
  // reset release
  //----------------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_n_reg;

  // async assert, two-stage synchronous release
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  //----------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------
  logic [6:0]  enable_reg;
  logic [6:0]  request_reg;
  logic [6:0]  request_set;
  logic [7:0]  portsel_reg;
  logic [7:0]  port_prev_reg;
  logic        ext_prev_reg;
  logic [1:0]  conv_cnt_reg;
  logic        conv_prev_reg;
  logic [6:0]  evstat_reg;
  logic [6:0]  evmask_reg;
  logic        halt_saved_reg;
  ssic_state_t state_reg;
  logic [2:0]  grant_idx;
  logic        grant_any;
  logic [6:0]  grant_oh;
  logic [11:0] grant_vec;
  logic        accept;
  logic        apb_done;
  logic        apb_wr;
  logic        apb_rd;
  logic        apb_hit;
  logic [31:0] rd_mux;
  logic [6:0]  wr_mask;
  logic        conv_fall;
  logic [1:0]  conv_cnt_inc;
  logic        port_c_chg;
  logic        port_d_chg;
  logic        wr_enable;
  logic        wr_request;
  logic        wr_portsel;
  logic        wr_evmask;
  logic        rd_evstat;
  logic [6:0]  req_clear;

  //----------------------------------------------------------------------
  // apb decode
  //----------------------------------------------------------------------
  // transfer completes on the edge where pready is seen high
  assign apb_done = i_psel & i_penable & o_pready;
  assign apb_wr   = apb_done & i_pwrite;
  assign apb_rd   = apb_done & ~i_pwrite;
  assign wr_mask  = i_pwdata[6:0];

  // per-register strobes, all on the completing edge
  assign wr_enable  = apb_wr & (i_paddr == `SSIC_OFS_ENABLE);
  assign wr_request = apb_wr & (i_paddr == `SSIC_OFS_REQUEST);
  assign wr_portsel = apb_wr & (i_paddr == `SSIC_OFS_PORTSEL);
  assign wr_evmask  = apb_wr & (i_paddr == `SSIC_OFS_EVMASK);
  assign rd_evstat  = apb_rd & (i_paddr == `SSIC_OFS_EVSTAT);
  assign req_clear  = wr_request ? wr_mask : 7'h00;

  // read data mux, also flags unmapped offsets
  always_comb begin
    rd_mux  = 32'h0000_0000;
    apb_hit = 1'b1;
    unique case (i_paddr)
      `SSIC_OFS_ENABLE:  rd_mux[6:0] = enable_reg;
      `SSIC_OFS_REQUEST: rd_mux[6:0] = request_reg;
      `SSIC_OFS_PORTSEL: rd_mux[7:0] = portsel_reg;
      `SSIC_OFS_EVSTAT:  rd_mux[6:0] = evstat_reg;
      `SSIC_OFS_EVMASK:  rd_mux[6:0] = evmask_reg;
      `SSIC_OFS_STATE:   rd_mux[3:0] = {halt_saved_reg, o_conv_halt,
                                        state_reg != SSIC_IDLE, grant_any};
      default:           apb_hit     = 1'b0;
    endcase
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~apb_hit;
      if (i_psel & i_penable & ~o_pready & ~i_pwrite) begin
        o_prdata <= rd_mux;
      end
    end
  end

  //----------------------------------------------------------------------
  // request sources
  //----------------------------------------------------------------------
  // sampled history for change and edge detection
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      port_prev_reg <= `SSIC_RST_SEL;
      ext_prev_reg  <= 1'b0;
      conv_prev_reg <= 1'b0;
    end else begin
      port_prev_reg <= i_port_cd;
      ext_prev_reg  <= i_ext_pin;
      conv_prev_reg <= i_conv_pin;
    end
  end

  // falling edge on the converter counter pin, only in pin-control mode
  assign conv_fall    = i_conv_mode & conv_prev_reg & ~i_conv_pin;
  assign conv_cnt_inc = conv_cnt_reg + 2'h1;

  // change on any pin of a selected port; an unselected port never raises
  assign port_c_chg = (|(i_port_cd[3:0] ^ port_prev_reg[3:0]))
                      & portsel_reg[`SSIC_SEL_PORT_C];                   // RL16
  assign port_d_chg = (|(i_port_cd[7:4] ^ port_prev_reg[7:4]))
                      & portsel_reg[`SSIC_SEL_PORT_D];                   // RL16

  // converter counter pin: the second falling edge stops the count
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      conv_cnt_reg <= 2'h0;
      o_conv_halt  <= 1'b0;
    end else if (!i_conv_mode) begin
      conv_cnt_reg <= 2'h0;
      o_conv_halt  <= 1'b0;
    end else if (conv_fall && !o_conv_halt) begin
      conv_cnt_reg <= conv_cnt_inc;
      o_conv_halt  <= (conv_cnt_inc == `SSIC_CONV_SECOND_FALL);     // RL5
    end
  end

  // per-source raise terms; pin edge compares one registered sample with the live pin level
  always_comb begin
    request_set = 7'h00;
    request_set[`SSIC_SRC_PORT]   = port_c_chg | port_d_chg;         // RL1
    request_set[`SSIC_SRC_KEY]    = i_src.key_scan;                  // RL2
    request_set[`SSIC_SRC_TIMER1] = i_src.first_timer_uflow;         // RL3
    request_set[`SSIC_SRC_TIMER2] = i_src.second_timer_uflow;        // RL3
    request_set[`SSIC_SRC_PREDIV] = i_src.prediv_ovf;                // RL4
    request_set[`SSIC_SRC_CONV]   = conv_fall & ~o_conv_halt &
                                    (conv_cnt_inc == `SSIC_CONV_SECOND_FALL); // RL5
    request_set[`SSIC_SRC_PIN]    = EXT_RISING ? (~ext_prev_reg & i_ext_pin)
                                               : (ext_prev_reg & ~i_ext_pin); // RL17
  end

  //----------------------------------------------------------------------
  // priority select
  //----------------------------------------------------------------------
  // fixed order, first match wins; lower ones just stay pending
  always_comb begin
    logic [6:0] live;
    live      = request_reg & enable_reg;
    grant_any = |live;
    grant_idx = `SSIC_SRC_PREDIV;
    grant_vec = `SSIC_VEC_PREDIV;
    if (live[`SSIC_SRC_PREDIV]) begin                                // RL6
      grant_idx = `SSIC_SRC_PREDIV;
      grant_vec = `SSIC_VEC_PREDIV;
    end else if (live[`SSIC_SRC_TIMER1]) begin                       // RL7
      grant_idx = `SSIC_SRC_TIMER1;
      grant_vec = `SSIC_VEC_TIMER1;
    end else if (live[`SSIC_SRC_TIMER2]) begin
      grant_idx = `SSIC_SRC_TIMER2;
      grant_vec = `SSIC_VEC_TIMER2;
    end else if (live[`SSIC_SRC_CONV]) begin
      grant_idx = `SSIC_SRC_CONV;
      grant_vec = `SSIC_VEC_CONV;
    end else if (live[`SSIC_SRC_PORT]) begin
      grant_idx = `SSIC_SRC_PORT;
      grant_vec = `SSIC_VEC_PORT;
    end else if (live[`SSIC_SRC_PIN]) begin
      grant_idx = `SSIC_SRC_PIN;
      grant_vec = `SSIC_VEC_PIN;
    end else if (live[`SSIC_SRC_KEY]) begin
      grant_idx = `SSIC_SRC_KEY;
      grant_vec = `SSIC_VEC_KEY;
    end
  end

  // accept only at an instruction start and outside an entry sequence
  assign accept   = grant_any & i_instr_start & (state_reg == SSIC_IDLE); // RL11
  assign grant_oh = accept ? (7'h01 << grant_idx) : 7'h00;

  //----------------------------------------------------------------------
  // request and enable flags
  //----------------------------------------------------------------------
  // a new raise beats any clear in the same cycle, so nothing is lost
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      request_reg <= `SSIC_RST_FLAGS;
    end else begin
      request_reg <= (request_reg                                    // RL19
                      & ~grant_oh                                    // RL9
                      & ~req_clear)                                  // RL15
                     | request_set;
    end
  end

  // enables: written by software, all dropped on acceptance
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      enable_reg <= `SSIC_RST_FLAGS;
    end else if (accept) begin
      enable_reg <= `SSIC_RST_FLAGS;                                 // RL8
    end else if (wr_enable) begin
      enable_reg <= wr_mask;                                         // RL14
    end
  end

  // port-select operand
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      portsel_reg <= `SSIC_RST_SEL;
    end else if (wr_portsel) begin
      portsel_reg <= i_pwdata[7:0];                                  // RL16
    end
  end

  //----------------------------------------------------------------------
  // entry sequence to the cpu core
  //----------------------------------------------------------------------
  // accept cycle, then a nop that pushes pc, then vector fetch
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= SSIC_IDLE;
    end else begin
      unique case (state_reg)
        SSIC_IDLE:  if (accept) state_reg <= SSIC_STORE;              // RL11
        SSIC_STORE: state_reg <= SSIC_FETCH;
        SSIC_FETCH: state_reg <= SSIC_IDLE;
      endcase
    end
  end

  // cpu commands; pc of the accepted instruction is stacked so the
  // return replays it rather than skipping it
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_cpu <= '0;
    end else begin
      o_cpu.push <= accept;                                          // RL10
      o_cpu.nop  <= accept;                                          // RL11
      o_cpu.load <= (state_reg == SSIC_STORE);                       // RL10
      if (accept) begin
        o_cpu.ret_pc <= i_pc;                                        // RL12
        o_cpu.vector <= grant_vec;
      end
    end
  end

  // remember an interrupted halt; replayed when the routine returns
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      halt_saved_reg <= 1'b0;
      o_halt_return  <= 1'b0;
    end else begin
      o_halt_return <= i_rts & halt_saved_reg;                       // RL13
      if (accept) begin
        halt_saved_reg <= i_halt_instr;                              // RL13
      end else if (i_rts) begin
        halt_saved_reg <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------
  // event status and interrupt line
  //----------------------------------------------------------------------
  // acceptance per source is sticky; a read clears, a same-cycle set wins
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      evstat_reg <= `SSIC_RST_FLAGS;
    end else if (rd_evstat) begin
      // drop only the bits this read reported, so a late accept survives
      evstat_reg <= (evstat_reg & ~o_prdata[6:0]) | grant_oh;
    end else begin
      evstat_reg <= evstat_reg | grant_oh;
    end
  end

  // mask of the same layout
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      evmask_reg <= `SSIC_RST_FLAGS;
    end else if (wr_evmask) begin
      evmask_reg <= wr_mask;
    end
  end

  // registered level; lags status by one cycle
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evstat_reg & evmask_reg);
    end
  end

endmodule // ssic_top

// file: bench/ssic_cpu_model.sv
// cpu core stand-in driving the controller's instruction side
`timescale 1ns/100ps

module ssic_cpu_model
  import ssic_pkg::*;
(
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_arst_n,
  // bench controls
  input  wire logic      i_halt,
  input  wire logic      i_ret,
  // controller side
  input  wire ssic_cpu_t i_cpu,
  output logic           o_instr_start,
  output logic [11:0]    o_pc,
  output logic           o_halt_instr,
  output logic           o_rts
);
  logic [11:0] stack_reg;

  // no instruction runs in the no-op and vector-load cycles
  assign o_instr_start = ~i_cpu.push & ~i_cpu.load;
  assign o_halt_instr  = i_halt;
  assign o_rts         = i_ret;

  // return address saved on push; halt keeps the pc still
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stack_reg <= 12'h000;
      o_pc      <= 12'h000;
    end else begin
      if (i_cpu.push) stack_reg <= i_cpu.ret_pc;
      if (i_cpu.load) o_pc <= i_cpu.vector;
      else if (i_ret) o_pc <= stack_reg;
      else if (o_instr_start && !i_halt) o_pc <= o_pc + 12'h001;
    end
  end
endmodule // ssic_cpu_model

// file: bench/ssic_props.sv
// concurrent checks on the controller's ports
`timescale 1ns/100ps

module ssic_props
  import ssic_pkg::*;
(
  // clock, reset and apb
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // cpu side and sources
  input wire logic        i_instr_start,
  input wire logic [11:0] i_pc,
  input wire logic        i_rts,
  input wire ssic_cpu_t   o_cpu,
  input wire logic        o_halt_return,
  input wire logic        i_conv_mode,
  input wire logic        o_conv_halt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_entry_order: assert property (o_cpu.push |-> o_cpu.nop ##1 o_cpu.load ##1 !o_cpu.load)
    else $error("entry sequence out of order");
  a_ret_addr: assert property (o_cpu.push |-> $past(i_instr_start) && o_cpu.ret_pc == $past(i_pc))
    else $error("return address wrong");
  a_vector_table: assert property (o_cpu.load |-> o_cpu.vector inside
    {12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024, 12'h028})
    else $error("vector not in table");
  a_vector_held: assert property (o_cpu.load |-> $stable(o_cpu.vector) && $stable(o_cpu.ret_pc))
    else $error("vector moved during load");
  a_no_reaccept: assert property (o_cpu.push |=> !o_cpu.push [*2])
    else $error("accept during entry");
  a_apb_wait: assert property (i_psel && $rose(i_penable) |=> o_pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_halt_back: assert property (o_halt_return |-> $past(i_rts))
    else $error("halt return without rts");
  a_conv_mode: assert property ($rose(o_conv_halt) |-> i_conv_mode)
    else $error("counter halt outside pin mode");
endmodule // ssic_props

bind ssic_top ssic_props u_props (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pc(i_pc),
  .i_instr_start(i_instr_start), .i_rts(i_rts), .o_cpu(o_cpu), .o_halt_return(o_halt_return),
  .i_conv_mode(i_conv_mode), .o_conv_halt(o_conv_halt));

// file: bench/ssic_top_tb.sv
// self-checking bench for the seven-source interrupt controller
`timescale 1ns/100ps
`include "ssic_map.svh"

module ssic_top_tb
  import ssic_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n, psel, penable, pwrite, ext_pin, conv_mode, conv_pin, halt, ret, e;
  logic        pready, pslverr, conv_halt, halt_ret, irq, istart, hinstr, rts;
  logic [7:0]  paddr, port_cd;
  logic [31:0] pwdata, prdata, r, rem;
  logic [11:0] pc, p;
  ssic_src_t   src;
  ssic_cpu_t   cpu;
  int          compares = 0;
  int          miscompares = 0;
  int          n;
  // priority walk: enable masks, expected vectors, winning source
  logic [7:0]  en_mask [7] = '{8'h7f, 8'h77, 8'h75, 8'h65, 8'h25, 8'h24, 8'h20};
  logic [11:0] vec [7] = '{12'h01c, 12'h018, 12'h020, 12'h028, 12'h014, 12'h010, 12'h024};
  int          idx [7] = '{3, 1, 4, 6, 0, 2, 5};

  always #12.5 clk = ~clk;

  ssic_top u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_src(src), .i_port_cd(port_cd),
    .i_ext_pin(ext_pin), .i_conv_mode(conv_mode), .i_conv_pin(conv_pin), .o_conv_halt(conv_halt),
    .i_instr_start(istart), .i_pc(pc), .i_halt_instr(hinstr), .i_rts(rts), .o_cpu(cpu),
    .o_halt_return(halt_ret), .o_irq(irq));
  ssic_cpu_model u_cpu (.i_clk(clk), .i_arst_n(arst_n), .i_halt(halt), .i_ret(ret),
    .i_cpu(cpu), .o_instr_start(istart), .o_pc(pc), .o_halt_instr(hinstr), .o_rts(rts));

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    chk(n < 20, 1, "apb no answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, 32'h0);
    chk(r, x, m);
  endtask

  task automatic wait_load();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpu.load !== 1'b1 && n < 50);
    chk(n < 50, 1, "no vector load");
  endtask

  // watchdog: the whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    {arst_n, psel, penable, pwrite, ext_pin, halt, ret} = '0;
    {paddr, port_cd, pwdata, src} = '0;
    conv_mode = 1'b1;
    conv_pin = 1'b1;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(`SSIC_OFS_ENABLE, 32'h0, "enable reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1, "unmapped err");
    chk(r, 0, "unmapped data");
    apb(1'b1, `SSIC_OFS_PORTSEL, 32'h10);
    port_cd <= 8'h10;
    repeat (3) @(posedge clk);
    rdc(`SSIC_OFS_REQUEST, 32'h0, "port d not selected");
    // every source fires at once, the converter two cycles later on its second fall; pin was low for many cycles first
    src <= '1;
    ext_pin <= 1'b1;
    port_cd <= 8'h11;
    conv_pin <= 1'b0;
    @(posedge clk);
    src <= '0;
    conv_pin <= 1'b1;
    @(posedge clk);
    conv_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(`SSIC_OFS_REQUEST, 32'h7f, "all pending");
    chk(conv_halt, 1, "counter halt");
    // state word: counter halted, nothing enabled, no entry running
    rdc(`SSIC_OFS_STATE, 32'h4, "state word");
    rem = 32'h7f;
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, `SSIC_OFS_ENABLE, {24'h0, en_mask[i]});
      wait_load();
      chk(cpu.vector, vec[i], "vector order");
      rem[idx[i]] = 1'b0;
      rdc(`SSIC_OFS_REQUEST, rem, "others stay pending");
      rdc(`SSIC_OFS_ENABLE, 32'h0, "enables cleared");
    end
    chk(irq, 0, "masked irq");
    apb(1'b1, `SSIC_OFS_EVMASK, 32'h7f);
    repeat (2) @(posedge clk);
    chk(irq, 1, "irq raised");
    rdc(`SSIC_OFS_EVSTAT, 32'h7f, "all accepted");
    rdc(`SSIC_OFS_EVSTAT, 32'h0, "read clears");
    chk(irq, 0, "irq cleared");
    // accept during a halt instruction, then return
    halt <= 1'b1;
    src.first_timer_uflow <= 1'b1;
    @(posedge clk);
    src <= '0;
    p = pc;
    apb(1'b1, `SSIC_OFS_ENABLE, 32'h02);
    wait_load();
    chk(cpu.vector, 12'h018, "timer vector");
    chk(cpu.ret_pc, p, "return address");
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(posedge clk);
    chk(halt_ret, 1, "back to halt");
    chk(pc, p, "re-execute");
    halt <= 1'b0;
    src <= '1;
    @(posedge clk);
    src <= '0;
    repeat (2) @(posedge clk);
    rdc(`SSIC_OFS_REQUEST, 32'h3a, "timer pending");
    apb(1'b1, `SSIC_OFS_REQUEST, 32'h02);
    rdc(`SSIC_OFS_REQUEST, 32'h38, "timer 1 cleared only");
    apb(1'b1, `SSIC_OFS_REQUEST, 32'h7f);
    rdc(`SSIC_OFS_REQUEST, 32'h0, "cleared");
    // leaving pin-control mode releases the counter halt
    conv_mode <= 1'b0;
    repeat (2) @(posedge clk);
    chk(conv_halt, 0, "halt drops with mode");
    end_of_test();
  end
endmodule // ssic_top_tb
